// [logic/acp_cfg.svh]
// constants for the converter control and output port
`ifndef ACP_CFG_SVH
`define ACP_CFG_SVH

`define ACP_ADDR_DAC_LO 2'h0
`define ACP_ADDR_DAC_HI 2'h1
`define ACP_ADDR_CTRL 2'h2
`define ACP_ADDR_RESV 2'h3

`define ACP_CTRL_RESET 7'h01
`define ACP_DAC_LO_RESET 8'h00
`define ACP_DAC_HI_RESET 2'h0
`define ACP_BIT_PDWN 3
`define ACP_BIT_CLAMP_SOURCE_INTERNAL 4
`define ACP_BIT_SIGNED 5
`define ACP_BIT_CLAMP_CIRCUIT_DISABLE 6

`define ACP_WAKE_CYCLES 16'h0040

`define ACP_SW_STATUS 4'h0
`define ACP_SW_CLEAR 4'h1
`define ACP_SW_ENABLE 4'h2
`define ACP_SW_CTRL 4'h3
`define ACP_SW_DAC 4'h4
`define ACP_SW_STATE 4'h5

`define ACP_EV_WRITE 0
`define ACP_EV_RESV 1
`define ACP_EV_OVER 2
`define ACP_EV_WAKE 3

`endif

// [logic/acp_host_write.sv]
// catches a host register write on the falling edge of the write strobe
`timescale 1ns/100ps
`include "acp_cfg.svh"
module acp_host_write
    import acp_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [9:0] io_in,
    input wire logic out_drive_en_n,
    input wire logic wr_strobe,
    acp_wr_if.src wr
);
    logic wr_q_r, wr_q_nxt;
    logic [9:0] hold_r, hold_nxt;
    logic fire_r, fire_nxt, resv_r, resv_nxt;
    logic [1:0] addr_r, addr_nxt;
    logic [7:0] data_r, data_nxt;
    logic fall;

    always_comb begin
        wr_q_nxt = wr_strobe;
        // the word is taken while the strobe is high, so it is settled at the fall
        hold_nxt = wr_strobe ? io_in : hold_r;
        fall = wr_q_r && !wr_strobe && out_drive_en_n;
        fire_nxt = fall && (hold_r[9:8] != `ACP_ADDR_RESV);
        resv_nxt = fall && (hold_r[9:8] == `ACP_ADDR_RESV);
        addr_nxt = fall ? hold_r[9:8] : addr_r;
        data_nxt = fall ? hold_r[7:0] : data_r;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q_r <= 1'b0;
            hold_r <= 10'h000;
            fire_r <= 1'b0;
            resv_r <= 1'b0;
            addr_r <= 2'h0;
            data_r <= 8'h00;
        end else begin
            wr_q_r <= wr_q_nxt;
            hold_r <= hold_nxt;
            fire_r <= fire_nxt;
            resv_r <= resv_nxt;
            addr_r <= addr_nxt;
            data_r <= data_nxt;
        end
    end

    assign wr.fire = fire_r;
    assign wr.resv = resv_r;
    assign wr.addr = addr_r;
    assign wr.data = data_r;

    chk_fire_on_fall: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_q_r && !wr_strobe && out_drive_en_n |=> fire_r || resv_r)
        else $error("strobe fall did not produce a write");
    chk_no_fire_driving: assert property (@(posedge core_clk) disable iff (!rst_n)
        !out_drive_en_n |=> !fire_r && !resv_r)
        else $error("write taken while outputs driven");
endmodule

// [logic/acp_pkg.sv]
// types shared by the converter control and output port
package acp_pkg;
    typedef enum logic [1:0] {PWR_ON, PWR_DOWN, PWR_WAKE} acp_pwr_e;
    typedef logic [9:0] acp_code_t;
endpackage

// [logic/acp_port.sv]
// converter control and output port: host registers, clamp, power and result drive
`timescale 1ns/100ps
`include "acp_cfg.svh"
module acp_port
    import acp_pkg::*;
#(
    parameter logic [15:0] WAKE_CYCLES = `ACP_WAKE_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [9:0] io_in,
    output logic [9:0] io_out,
    output logic io_oe,
    output logic over_range_flag,
    output logic over_range_oe,
    input wire logic out_drive_en_n,
    input wire logic wr_strobe,
    input wire logic clamp_request,
    input wire logic conv_valid,
    input wire logic [9:0] conv_code,
    input wire logic conv_over,
    output logic clamp_drive_output,
    output logic clamp_source_internal,
    output logic [9:0] clamp_dac_code,
    output logic clamp_circuit_disable,
    output logic power_down_bit,
    output logic [2:0] gain_select,
    output logic results_valid,
    input wire logic [3:0] sw_addr,
    input wire logic [15:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [15:0] sw_rdata,
    output logic irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    function automatic acp_code_t fmt_code(input acp_code_t code, input logic signed_sel);
        // flipping the msb maps offset binary onto two's complement
        fmt_code = signed_sel ? {~code[9], code[8:0]} : code;
    endfunction

    acp_wr_if wr_bus ();

    acp_host_write u_host_write (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .io_in(io_in),
        .out_drive_en_n(out_drive_en_n),
        .wr_strobe(wr_strobe),
        .wr(wr_bus.src)
    );

    // host registers
    logic [6:0] ctrl_r, ctrl_nxt;
    logic [7:0] dac_lo_r, dac_lo_nxt;
    logic [1:0] dac_hi_r, dac_hi_nxt;

    always_comb begin
        ctrl_nxt = ctrl_r;
        dac_lo_nxt = dac_lo_r;
        dac_hi_nxt = dac_hi_r;
        if (wr_bus.fire) begin
            unique case (wr_bus.addr)
                `ACP_ADDR_DAC_LO: dac_lo_nxt = wr_bus.data;
                `ACP_ADDR_DAC_HI: dac_hi_nxt = wr_bus.data[1:0];
                `ACP_ADDR_CTRL: ctrl_nxt = wr_bus.data[6:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= `ACP_CTRL_RESET;
            dac_lo_r <= `ACP_DAC_LO_RESET;
            dac_hi_r <= `ACP_DAC_HI_RESET;
        end else begin
            ctrl_r <= ctrl_nxt;
            dac_lo_r <= dac_lo_nxt;
            dac_hi_r <= dac_hi_nxt;
        end
    end

    // power state
    acp_pwr_e pwr_r, pwr_nxt;
    logic [15:0] wake_cnt_r, wake_cnt_nxt;
    logic wake_ev;
    logic valid_r, valid_nxt;

    always_comb begin
        pwr_nxt = pwr_r;
        wake_cnt_nxt = wake_cnt_r;
        wake_ev = 1'b0;
        unique case (pwr_r)
            PWR_ON: begin
                if (ctrl_r[`ACP_BIT_PDWN]) begin
                    pwr_nxt = PWR_DOWN;
                end
            end
            PWR_DOWN: begin
                if (!ctrl_r[`ACP_BIT_PDWN]) begin
                    pwr_nxt = PWR_WAKE;
                    wake_cnt_nxt = WAKE_CYCLES - 16'h0001;
                end
            end
            PWR_WAKE: begin
                if (ctrl_r[`ACP_BIT_PDWN]) begin
                    pwr_nxt = PWR_DOWN;
                end else if (wake_cnt_r == 16'h0000) begin
                    pwr_nxt = PWR_ON;
                    wake_ev = 1'b1;
                end else begin
                    wake_cnt_nxt = wake_cnt_r - 16'h0001;
                end
            end
        endcase
        // registered copy so the pin comes straight from a flop, same timing as the state
        valid_nxt = (pwr_nxt == PWR_ON);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_r <= PWR_ON;
            wake_cnt_r <= 16'h0000;
            valid_r <= 1'b1;
        end else begin
            pwr_r <= pwr_nxt;
            wake_cnt_r <= wake_cnt_nxt;
            valid_r <= valid_nxt;
        end
    end

    // result drive and clamp
    logic [9:0] out_r, out_nxt;
    logic ovr_r, ovr_nxt, oe_r, oe_nxt, clamp_r, clamp_nxt, over_ev;

    always_comb begin
        out_nxt = out_r;
        ovr_nxt = ovr_r;
        over_ev = 1'b0;
        if (conv_valid && pwr_r == PWR_ON) begin
            out_nxt = fmt_code(conv_code, ctrl_r[`ACP_BIT_SIGNED]);
            ovr_nxt = conv_over;
            over_ev = conv_over;
        end
        oe_nxt = !out_drive_en_n;
        // clamp switch, gated by disable and power
        clamp_nxt = clamp_request && !ctrl_r[`ACP_BIT_CLAMP_CIRCUIT_DISABLE] && pwr_r == PWR_ON;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_r <= 10'h000;
            ovr_r <= 1'b0;
            oe_r <= 1'b0;
            clamp_r <= 1'b0;
        end else begin
            out_r <= out_nxt;
            ovr_r <= ovr_nxt;
            oe_r <= oe_nxt;
            clamp_r <= clamp_nxt;
        end
    end

    // software side: events, mask, readback
    logic [3:0] sts_r, sts_nxt, en_r, en_nxt, ev;
    logic [15:0] rdata_r, rdata_nxt;
    logic irq_r, irq_nxt;

    always_comb begin
        ev = 4'h0;
        ev[`ACP_EV_WRITE] = wr_bus.fire;
        ev[`ACP_EV_RESV] = wr_bus.resv;
        ev[`ACP_EV_OVER] = over_ev;
        ev[`ACP_EV_WAKE] = wake_ev;
        sts_nxt = sts_r;
        en_nxt = en_r;
        if (sw_wr && sw_addr == `ACP_SW_CLEAR) begin
            sts_nxt = sts_nxt & ~sw_wdata[3:0];
        end
        if (sw_wr && sw_addr == `ACP_SW_ENABLE) begin
            en_nxt = sw_wdata[3:0];
        end
        // a new event outweighs a clear in the same cycle
        sts_nxt = sts_nxt | ev;
        irq_nxt = |(sts_nxt & en_nxt);
        rdata_nxt = 16'h0000;
        if (sw_rd) begin
            unique case (sw_addr)
                `ACP_SW_STATUS: rdata_nxt = {12'h000, sts_r};
                `ACP_SW_ENABLE: rdata_nxt = {12'h000, en_r};
                `ACP_SW_CTRL: rdata_nxt = {9'h000, ctrl_r};
                `ACP_SW_DAC: rdata_nxt = {6'h00, dac_hi_r, dac_lo_r};
                `ACP_SW_STATE: rdata_nxt = {12'h000, clamp_r, pwr_r == PWR_ON, pwr_r};
                default: rdata_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sts_r <= 4'h0;
            en_r <= 4'h0;
            rdata_r <= 16'h0000;
            irq_r <= 1'b0;
        end else begin
            sts_r <= sts_nxt;
            en_r <= en_nxt;
            rdata_r <= rdata_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign io_out = out_r;
    assign io_oe = oe_r;
    assign over_range_flag = ovr_r;
    assign over_range_oe = oe_r;
    assign clamp_drive_output = clamp_r;
    assign clamp_source_internal = ctrl_r[`ACP_BIT_CLAMP_SOURCE_INTERNAL];
    assign clamp_dac_code = {dac_hi_r, dac_lo_r};
    assign clamp_circuit_disable = ctrl_r[`ACP_BIT_CLAMP_CIRCUIT_DISABLE];
    assign power_down_bit = ctrl_r[`ACP_BIT_PDWN];
    assign gain_select = ctrl_r[2:0];
    assign results_valid = valid_r;
    assign sw_rdata = rdata_r;
    assign irq = irq_r;

    chk_clamp_closes: assert property (
        clamp_request && !ctrl_r[`ACP_BIT_CLAMP_CIRCUIT_DISABLE] && pwr_r == PWR_ON |=> clamp_drive_output)
        else $error("clamp did not close");
    chk_clamp_opens: assert property (
        !clamp_request |=> !clamp_drive_output)
        else $error("clamp closed without request");
    chk_clamp_disable: assert property (
        ctrl_r[`ACP_BIT_CLAMP_CIRCUIT_DISABLE] |=> !clamp_drive_output)
        else $error("clamp active while disabled");
    chk_pdwn_enter: assert property (
        wr_bus.fire && wr_bus.addr == `ACP_ADDR_CTRL && wr_bus.data[3] |=> ##2 pwr_r == PWR_DOWN)
        else $error("power down not entered");
    chk_wake_wait: assert property (
        pwr_r == PWR_DOWN && !ctrl_r[`ACP_BIT_PDWN] |=> !results_valid [*2])
        else $error("results valid before wake time");
    chk_drive_on: assert property (
        !out_drive_en_n |=> io_oe && over_range_oe)
        else $error("drivers not enabled");
    chk_drive_off: assert property (
        out_drive_en_n |=> !io_oe && !over_range_oe)
        else $error("drivers not released");
    chk_result_format: assert property (
        conv_valid && pwr_r == PWR_ON |=>
        io_out == fmt_code($past(conv_code), $past(ctrl_r[`ACP_BIT_SIGNED])))
        else $error("result format wrong");
    chk_dac_lo_load: assert property (
        wr_bus.fire && wr_bus.addr == `ACP_ADDR_DAC_LO |=>
        clamp_dac_code[7:0] == $past(wr_bus.data) && $stable(clamp_dac_code[9:8]))
        else $error("low dac byte not loaded");
    chk_dac_hi_load: assert property (
        wr_bus.fire && wr_bus.addr == `ACP_ADDR_DAC_HI |=>
        clamp_dac_code[9:8] == $past(wr_bus.data[1:0]) && $stable(ctrl_r))
        else $error("top dac bits not loaded");
    chk_ctrl_load: assert property (
        wr_bus.fire && wr_bus.addr == `ACP_ADDR_CTRL |=>
        ctrl_r == $past(wr_bus.data[6:0]) && $stable(clamp_dac_code))
        else $error("control register not loaded");
    chk_resv_ignored: assert property (
        wr_bus.resv |=> $stable(ctrl_r) && $stable(clamp_dac_code))
        else $error("reserved write changed state");
    chk_irq_level: assert property (
        (sts_r & en_r) != 4'h0 |-> irq)
        else $error("interrupt low with enabled event");

    cov_wake_cycle: cover property (pwr_r == PWR_WAKE ##1 pwr_r == PWR_ON);
    cov_signed_out: cover property (conv_valid && ctrl_r[`ACP_BIT_SIGNED] && pwr_r == PWR_ON);
    cov_dac_pair: cover property (wr_bus.fire && wr_bus.addr == `ACP_ADDR_DAC_LO
        ##[1:50] wr_bus.fire && wr_bus.addr == `ACP_ADDR_DAC_HI);
    cov_reserved: cover property (wr_bus.resv);
endmodule

// [logic/acp_wr_if.sv]
// decoded host register write passed from the strobe catcher to the core
`timescale 1ns/100ps
interface acp_wr_if;
    logic fire;
    logic resv;
    logic [1:0] addr;
    logic [7:0] data;
    modport src (output fire, output resv, output addr, output data);
    modport dst (input fire, input resv, input addr, input data);
endinterface

// [sim/acp_host_model.sv]
// host controller model: shares the ten data lines and strobes register writes
`timescale 1ns/100ps
module acp_host_model (
    input wire logic core_clk,
    input wire logic io_oe,
    input wire logic [9:0] io_out,
    output logic [9:0] io_in,
    output logic out_drive_en_n,
    output logic wr_strobe
);
    logic host_drive;
    logic [9:0] host_word;
    logic [9:0] float_r;

    initial begin
        host_drive = 1'b0;
        host_word = 10'h000;
        float_r = 10'h155;
        out_drive_en_n = 1'b1;
        wr_strobe = 1'b0;
    end

    // an undriven bus shows a changing pattern, never a stale value
    always @(posedge core_clk) begin
        float_r <= ~float_r;
    end

    assign io_in = io_oe ? io_out : (host_drive ? host_word : float_r);

    task automatic set_drive(input logic on);
        @(posedge core_clk);
        out_drive_en_n <= ~on;
    endtask

    // drive off, word on bus, strobe high then low
    task automatic write_reg(input logic [1:0] addr, input logic [7:0] data);
        @(posedge core_clk);
        out_drive_en_n <= 1'b1;
        // waits out the device turnaround before driving, avoiding contention
        repeat (2) @(posedge core_clk);
        host_drive <= 1'b1;
        host_word <= {addr, data};
        wr_strobe <= 1'b1;
        @(posedge core_clk);
        wr_strobe <= 1'b0;
        // word held through the edge that sees the strobe low
        @(posedge core_clk);
        host_drive <= 1'b0;
    endtask

    // dac code as low byte then top bits; address 11 only when asked
    task automatic write_dac(input logic [9:0] code);
        write_reg(2'h0, code[7:0]);
        write_reg(2'h1, {6'h00, code[9:8]});
    endtask
endmodule

// [sim/adc_control_and_output_port_tb_top.sv]
// self-checking bench for the converter control and output port
`timescale 1ns/100ps
module adc_control_and_output_port_tb_top;
    import acp_pkg::*;
    localparam logic [15:0] WAKE = 16'h0004;
    logic core_clk, rst_n, out_drive_en_n, wr_strobe, clamp_request, conv_valid, conv_over;
    logic io_oe, over_range_flag, over_range_oe, clamp_drive_output, clamp_source_internal;
    logic clamp_circuit_disable, power_down_bit, results_valid, sw_wr, sw_rd, irq;
    logic [9:0] io_in, io_out, conv_code, clamp_dac_code, code, held;
    logic [2:0] gain_select;
    logic [3:0] sw_addr;
    logic [15:0] sw_wdata, sw_rdata, rd;
    logic [6:0] ctrl;
    int errors, compares, cycles;

    acp_port #(.WAKE_CYCLES(WAKE)) DUT (.core_clk(core_clk), .rst_n(rst_n), .io_in(io_in),
        .io_out(io_out), .io_oe(io_oe), .over_range_flag(over_range_flag),
        .over_range_oe(over_range_oe), .out_drive_en_n(out_drive_en_n), .wr_strobe(wr_strobe),
        .clamp_request(clamp_request), .conv_valid(conv_valid), .conv_code(conv_code),
        .conv_over(conv_over), .clamp_drive_output(clamp_drive_output),
        .clamp_source_internal(clamp_source_internal), .clamp_dac_code(clamp_dac_code),
        .clamp_circuit_disable(clamp_circuit_disable), .power_down_bit(power_down_bit),
        .gain_select(gain_select), .results_valid(results_valid), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(irq));

    acp_host_model host (.core_clk(core_clk), .io_oe(io_oe), .io_out(io_out), .io_in(io_in),
        .out_drive_en_n(out_drive_en_n), .wr_strobe(wr_strobe));

    always #10 core_clk = ~core_clk;

    task automatic conclude();
        if (errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ceiling well above the few hundred cycles the sequence needs
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            conclude();
        end
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h got %h", what, exp, got);
        end
    endtask

    function automatic logic [9:0] exp_code(input logic [9:0] c, input logic s);
        return s ? {~c[9], c[8:0]} : c;
    endfunction

    task automatic settle();
        repeat (3) @(posedge core_clk);
        #1;
    endtask

    task automatic sw_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        sw_wr <= 1'b1;
        sw_addr <= a;
        sw_wdata <= d;
        @(posedge core_clk);
        sw_wr <= 1'b0;
    endtask

    task automatic sw_read(input logic [3:0] a, output logic [15:0] d);
        @(posedge core_clk);
        sw_rd <= 1'b1;
        sw_addr <= a;
        @(posedge core_clk);
        sw_rd <= 1'b0;
        #1;
        d = sw_rdata;
    endtask

    task automatic convert(input logic [9:0] c, input logic o);
        @(posedge core_clk);
        conv_valid <= 1'b1;
        conv_code <= c;
        conv_over <= o;
        @(posedge core_clk);
        conv_valid <= 1'b0;
        #1;
    endtask

    initial begin
        core_clk = 0;
        rst_n = 0;
        clamp_request = 0;
        conv_valid = 0;
        conv_over = 0;
        conv_code = 10'h000;
        sw_addr = 4'h0;
        sw_wdata = 16'h0000;
        sw_wr = 0;
        sw_rd = 0;
        errors = 0;
        compares = 0;
        cycles = 0;
        void'($urandom(4));
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        #1;
        check("gain_reset", 16'h0001, {13'h0, gain_select});
        check("source_reset", 16'h0000, {15'h0, clamp_source_internal});
        check("pdwn_reset", 16'h0001, {15'h0, results_valid});
        check("dac_reset", 16'h0000, {6'h0, clamp_dac_code});
        sw_write(4'h2, 16'h0001);
        host.write_dac(10'h10F);
        settle();
        check("dac_10f", 16'h010F, {6'h0, clamp_dac_code});
        check("oe_off", 16'h0000, {14'h0, io_oe, over_range_oe});
        check("irq_write", 16'h0001, {15'h0, irq});
        sw_read(4'h0, rd);
        check("status_write", 16'h0001, rd & 16'h0001);
        sw_write(4'h1, 16'h000F);
        settle();
        check("irq_clear", 16'h0000, {15'h0, irq});
        sw_write(4'h2, 16'h0000);
        // random codes, boundaries first
        for (int i = 0; i < 6; i++) begin
            code = (i == 0) ? 10'h3FF : (i == 1) ? 10'h000 : 10'($urandom);
            host.write_dac(code);
            settle();
            check("dac_code", {6'h0, code}, {6'h0, clamp_dac_code});
            sw_read(4'h4, rd);
            check("dac_read", {6'h0, code}, rd);
        end
        check("irq_masked", 16'h0000, {15'h0, irq});
        // reserved address must leave every host register alone
        host.write_reg(2'h3, 8'hFF);
        settle();
        check("resv_dac", {6'h0, code}, {6'h0, clamp_dac_code});
        check("resv_gain", 16'h0001, {13'h0, gain_select});
        sw_read(4'h0, rd);
        check("status_resv", 16'h0002, rd & 16'h0002);
        sw_read(4'h9, rd);
        check("unmapped", 16'h0000, rd);
        // every gain code, alternating output format
        for (int g = 0; g < 8; g++) begin
            ctrl = {1'($urandom), g[0], 1'($urandom), 1'b0, 3'(g)};
            host.write_reg(2'h2, {1'b0, ctrl});
            settle();
            check("gain", {13'h0, ctrl[2:0]}, {13'h0, gain_select});
            check("source", {15'h0, ctrl[4]}, {15'h0, clamp_source_internal});
            check("clamp_circuit_disable", {15'h0, ctrl[6]}, {15'h0, clamp_circuit_disable});
            check("dac_kept", {6'h0, code}, {6'h0, clamp_dac_code});
            sw_read(4'h3, rd);
            check("ctrl_read", {9'h0, ctrl}, rd);
            host.set_drive(1'b1);
            repeat (2) @(posedge core_clk);
            #1;
            check("oe_on", 16'h0003, {14'h0, io_oe, over_range_oe});
            for (int k = 0; k < 3; k++) begin
                convert(10'($urandom), 1'($urandom));
                check("result", {6'h0, exp_code(conv_code, ctrl[5])}, {6'h0, io_out});
                check("over", {15'h0, conv_over}, {15'h0, over_range_flag});
            end
            @(posedge core_clk);
            clamp_request <= 1'b1;
            settle();
            check("clamp", {15'h0, ~ctrl[6]}, {15'h0, clamp_drive_output});
            @(posedge core_clk);
            clamp_request <= 1'b0;
            settle();
            check("clamp_open", 16'h0000, {15'h0, clamp_drive_output});
        end
        // power down drops results; waking waits out the wake count
        host.write_reg(2'h2, 8'h09);
        settle();
        check("pdwn_bit", 16'h0001, {15'h0, power_down_bit});
        check("pdwn_valid", 16'h0000, {15'h0, results_valid});
        host.set_drive(1'b1);
        repeat (2) @(posedge core_clk);
        #1;
        held = io_out;
        convert(~held, 1'b0);
        check("pdwn_hold", {6'h0, held}, {6'h0, io_out});
        host.write_reg(2'h2, 8'h01);
        settle();
        check("wake_valid", 16'h0000, {15'h0, results_valid});
        repeat (10) @(posedge core_clk);
        #1;
        check("awake_valid", 16'h0001, {15'h0, results_valid});
        sw_read(4'h0, rd);
        check("status_wake", 16'h0008, rd & 16'h0008);
        conclude();
    end
endmodule
